// file: include/csil_regs.vh
// constants for the sideband init, lock and local interrupt block
`ifndef CSIL_REGS_VH
`define CSIL_REGS_VH
`define CSIL_SYNC_STAGES      2
`define CSIL_RESET_RELEASE_NS 20
`define CSIL_CLK_PERIOD_NS    10
`define CSIL_RESET_RELEASE_CYC ((`CSIL_RESET_RELEASE_NS)/(`CSIL_CLK_PERIOD_NS))
`define CSIL_ST_IDLE   5'h01
`define CSIL_ST_SELF   5'h02
`define CSIL_ST_FETCH  5'h04
`define CSIL_ST_RUN    5'h08
`define CSIL_ST_INIT   5'h10
`define CSIL_VECTOR_DEFAULT 32'h00000000
`endif

// file: rtl/csil_sideband.v
// sideband control: soft init, self-check strap, local int pins, bus lock
// Functional notes
// - soft init resets integer registers, keeps caches and float registers
// - after soft init, fetch restarts at configured reset vector
// - snoop service and results continue while soft init is held
// - soft init sampled at hard reset release; active means run self-check
// - soft init is asynchronous, shared, synchronised before use
// - controller off: pin 0 is maskable irq, pin 1 is nonmaskable irq
// - software selects pin mode; controller enabled by default after reset
// - bus lock held from first transaction start to last transaction end
// - on hard reset all bus outputs deassert within two clocks
`timescale 1ns/1ps
`include "csil_regs.vh"

module csil_sideband (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        ignore_numeric_error_n,
    input  wire        soft_init_n,
    input  wire [1:0]  local_int_pins,
    input  wire        local_int_ctrl_enable,
    input  wire [31:0] reset_vector_cfg,
    input  wire        lock_request,
    input  wire        lock_seq_last_done,
    input  wire        snoop_request,
    input  wire        snoop_hit_in,
    input  wire        snoop_hitm_in,
    input  wire        priority_agent_request_n,
    output reg         ignore_numeric_error,
    output reg         int_reg_clear,
    output reg         fetch_start,
    output reg  [31:0] fetch_vector,
    output reg         built_in_self_check,
    output reg         self_check_start,
    output reg         maskable_irq,
    output reg         nonmaskable_irq,
    output reg  [1:0]  local_int_req,
    output reg         snoop_valid,
    output reg         snoop_hit_n,
    output reg         snoop_hitm_n,
    output reg         bus_lock_n,
    output wire        priority_agent_pending
);

// ----------------------------------------------------------------------
// helper functions
// ----------------------------------------------------------------------
// active-low pin to active-high level
function act_low;
    input pinN;
    begin
        act_low = ~pinN;
    end
endfunction

// one-hot state match
function st_is;
    input [4:0] st;
    input [4:0] code;
    begin
        st_is = (st == code);
    end
endfunction

// active-low snoop result, only while a snoop is requested
function snoop_res_n;
    input req;
    input hit;
    begin
        snoop_res_n = ~(req & hit);
    end
endfunction

// lock level from held state, end of sequence and new request
function lock_level;
    input held;
    input lastDone;
    input request;
    begin
        lock_level = (held & ~lastDone) | (~held & request);
    end
endfunction

// ----------------------------------------------------------------------
// synchronisers
// ----------------------------------------------------------------------
reg [3:0] syncA_reg;
reg [3:0] syncB_reg;
wire [3:0] asyncIn;
assign asyncIn = {local_int_pins, soft_init_n, ignore_numeric_error_n};

// no reset: the soft init strap must reach the core as reset releases
always @(posedge ref_clk) begin
    syncA_reg <= asyncIn;
    syncB_reg <= syncA_reg;
end

wire ignSync;
wire initActive;
wire [1:0] lintSync;
assign ignSync    = act_low(syncB_reg[0]);
assign initActive = act_low(syncB_reg[1]);
assign lintSync   = syncB_reg[3:2];

// ----------------------------------------------------------------------
// reset release strap and init sequencing
// ----------------------------------------------------------------------
reg       rstDly_reg;
reg [4:0] state_reg;
reg [4:0] state_next;
reg       initPrev_reg;

always @(posedge ref_clk) begin
    rstDly_reg <= rst;
end

wire rstRelease;
assign rstRelease = rstDly_reg & ~rst;

always @* begin
    state_next = state_reg;
    case (state_reg)
        `CSIL_ST_IDLE: begin
            if (rstRelease) begin
                if (initActive) begin
                    state_next = `CSIL_ST_SELF;
                end else begin
                    state_next = `CSIL_ST_FETCH;
                end
            end
        end
        `CSIL_ST_SELF:  state_next = `CSIL_ST_FETCH;
        `CSIL_ST_FETCH: state_next = `CSIL_ST_RUN;
        `CSIL_ST_RUN: begin
            if (initActive & ~initPrev_reg) begin
                state_next = `CSIL_ST_INIT;
            end
        end
        `CSIL_ST_INIT: begin
            if (~initActive) begin
                state_next = `CSIL_ST_FETCH;
            end
        end
        default: state_next = `CSIL_ST_IDLE;
    endcase
end

always @(posedge ref_clk) begin
    if (rst) begin
        state_reg           <= `CSIL_ST_IDLE;
        initPrev_reg        <= 1'b0;
        int_reg_clear       <= 1'b0;
        fetch_start         <= 1'b0;
        fetch_vector        <= `CSIL_VECTOR_DEFAULT;
        built_in_self_check <= 1'b0;
        self_check_start    <= 1'b0;
        ignore_numeric_error <= 1'b0;
    end else begin
        state_reg     <= state_next;
        initPrev_reg  <= initActive;
        // integer state only; caches and float registers untouched
        int_reg_clear <= st_is(state_next, `CSIL_ST_INIT);
        fetch_start   <= st_is(state_next, `CSIL_ST_FETCH);
        fetch_vector  <= reset_vector_cfg;
        self_check_start <= st_is(state_next, `CSIL_ST_SELF);
        if (rstRelease) begin
            built_in_self_check <= initActive;
        end
        ignore_numeric_error <= ignSync;
    end
end

// ----------------------------------------------------------------------
// local interrupt pins
// ----------------------------------------------------------------------
always @(posedge ref_clk) begin
    if (rst) begin
        maskable_irq    <= 1'b0;
        nonmaskable_irq <= 1'b0;
        local_int_req   <= 2'h0;
    end else if (local_int_ctrl_enable) begin
        maskable_irq    <= 1'b0;
        nonmaskable_irq <= 1'b0;
        local_int_req   <= lintSync;
    end else begin
        maskable_irq    <= lintSync[0];
        nonmaskable_irq <= lintSync[1];
        local_int_req   <= 2'h0;
    end
end

// ----------------------------------------------------------------------
// snoop service and bus lock
// ----------------------------------------------------------------------
reg lockHeld_reg;

always @(posedge ref_clk) begin
    if (rst) begin
        snoop_valid  <= 1'b0;
        snoop_hit_n  <= 1'b1;
        snoop_hitm_n <= 1'b1;
        bus_lock_n   <= 1'b1;
        lockHeld_reg <= 1'b0;
    end else begin
        // independent of the init state machine
        snoop_valid  <= snoop_request;
        snoop_hit_n  <= snoop_res_n(snoop_request, snoop_hit_in);
        snoop_hitm_n <= snoop_res_n(snoop_request, snoop_hitm_in);
        if (lockHeld_reg) begin
            if (lock_seq_last_done) begin
                lockHeld_reg <= 1'b0;
            end
        end else if (lock_request) begin
            lockHeld_reg <= 1'b1;
        end
        bus_lock_n <= ~lock_level(lockHeld_reg, lock_seq_last_done,
                                  lock_request);
    end
end

// priority agent must wait while lock is asserted
assign priority_agent_pending = ~priority_agent_request_n & ~bus_lock_n;

endmodule // csil_sideband

// file: verif/csil_partner.sv
// far-side agent model: priority requester that honours bus lock
`timescale 1ns/1ps
module csil_partner (
    input  wire  ref_clk, rst, bus_lock_n, want,
    output logic priority_agent_request_n, owns);
    always @(posedge ref_clk) begin
        priority_agent_request_n <= rst | ~want;
        owns <= ~rst & want & bus_lock_n;
    end
endmodule // csil_partner

// file: verif/csil_sideband_asserts.sv
// port assertions for the sideband block
`timescale 1ns/1ps
module csil_sideband_asserts (
    input wire ref_clk, rst, soft_init_n, ignore_numeric_error_n,
    input wire local_int_ctrl_enable, lock_request, lock_seq_last_done,
    input wire snoop_request, snoop_hit_in, ignore_numeric_error,
    input wire maskable_irq, nonmaskable_irq, int_reg_clear, fetch_start,
    input wire self_check_start, snoop_valid, snoop_hit_n, bus_lock_n,
    input wire [1:0] local_int_pins);
    logic [1:0] up;
    always @(posedge ref_clk) up <= rst ? 2'h0 : up + {1'b0, ~&up};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence held; $fell(soft_init_n) ##1 !soft_init_n [*5]; endsequence
    sequence boot; self_check_start ##1 fetch_start; endsequence
    a_lock_on: assert property (lock_request && !lock_seq_last_done |=>
        !bus_lock_n) else $error("lock not taken");
    a_lock_off: assert property (lock_seq_last_done |=> bus_lock_n)
        else $error("lock not freed");
    a_reset_quiet: assert property (disable iff (1'b0) rst ##1 rst |->
        bus_lock_n && snoop_hit_n && !fetch_start) else $error("reset");
    a_self_boot: assert property ($fell(rst) && !soft_init_n &&
        $past(!soft_init_n, 3) |=> boot) else $error("self check");
    a_snoop_follow: assert property (snoop_request |=> snoop_valid &&
        snoop_hit_n == !$past(snoop_hit_in)) else $error("snoop");
    a_init_clear: assert property (held |-> int_reg_clear)
        else $error("soft init");
    a_irq_map: assert property (up == 3 && local_int_ctrl_enable ==
        $past(local_int_ctrl_enable, 3) |-> {nonmaskable_irq, maskable_irq} ==
        (local_int_ctrl_enable ? 2'h0 : $past(local_int_pins, 3)))
        else $error("irq map");
    a_ign_sync: assert property (up == 3 |-> ignore_numeric_error ==
        !$past(ignore_numeric_error_n, 3)) else $error("ignore sync");
endmodule // csil_sideband_asserts

// file: verif/csil_sideband_tb.sv
// self-checking bench for the sideband block
`timescale 1ns/1ps
module csil_sideband_tb;
    logic ref_clk = 0, rst = 1, ignore_numeric_error_n = 1, soft_init_n = 0;
    logic local_int_ctrl_enable = 1, lock_request = 0, lock_seq_last_done = 0;
    logic snoop_request = 0, snoop_hit_in = 0, snoop_hitm_in = 0, want = 0;
    logic [1:0] local_int_pins = 0;
    logic [31:0] reset_vector_cfg = 32'h00001230;
    wire ignore_numeric_error, int_reg_clear, fetch_start, self_check_start;
    wire built_in_self_check, maskable_irq, nonmaskable_irq, snoop_valid;
    wire snoop_hit_n, snoop_hitm_n, bus_lock_n, priority_agent_pending;
    wire priority_agent_request_n;
    wire [31:0] fetch_vector;
    wire [1:0] local_int_req;
    integer n_mismatch = 0, samples_checked = 0, i, seed = 32'h221194cf;
    logic prevSnoop, prevHit, prevHitm, fetched = 0;
    always #5 ref_clk = ~ref_clk;
    csil_sideband uut (.*);
    csil_partner fa (.ref_clk, .rst, .bus_lock_n, .want,
        .priority_agent_request_n, .owns());
    function [1:0] exp_irq(input c, input [1:0] p);
        exp_irq = c ? 2'h0 : p;
    endfunction
    function [1:0] exp_req(input c, input [1:0] p);
        exp_req = c ? p : 2'h0;
    endfunction
    task chk(input [31:0] e, input [31:0] s, input string nm);
        samples_checked++;
        if (e !== s) begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", nm, e, s);
        end
    endtask
    task summarize;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 0;
        @(posedge ref_clk) soft_init_n <= 1;
        for (i = 0; i < 9; i++) begin
            @(negedge ref_clk);
            if (self_check_start === 1'b1) break;
        end
        chk(1, self_check_start, "selfStart");
        @(negedge ref_clk) chk(1, fetch_start, "fetch");
        chk(reset_vector_cfg, fetch_vector, "vector");
        chk(1, built_in_self_check, "selfFlag");
        $display("boot test done");
        for (i = 0; i < 120; i++) begin
            @(posedge ref_clk);
            prevSnoop = snoop_request;
            prevHit = snoop_hit_in;
            prevHitm = snoop_hitm_in;
            {snoop_request, snoop_hit_in, snoop_hitm_in, want} <=
                4'($random(seed));
            lock_request <= (i == 50);
            lock_seq_last_done <= (i == 70);
            soft_init_n <= !(i >= 90 && i < 100);
            if (i % 4 == 0)
                {local_int_pins, ignore_numeric_error_n} <= 3'($random(seed));
            if (i % 40 == 0) local_int_ctrl_enable <= 1'($random(seed));
            @(negedge ref_clk);
            chk(prevSnoop, snoop_valid, "snoop");
            chk(!(prevSnoop & prevHit), snoop_hit_n, "hit");
            chk(!(prevSnoop & prevHitm), snoop_hitm_n, "hitm");
            chk(!(i > 50 && i < 71), bus_lock_n, "lock");
            chk(!priority_agent_request_n & !bus_lock_n,
                priority_agent_pending, "pend");
            if (i > 100 && fetch_start === 1'b1) fetched = 1;
            if (i == 98) chk(1, int_reg_clear, "clear");
            if (i % 4 == 3) begin
                chk(exp_irq(local_int_ctrl_enable, local_int_pins),
                    {nonmaskable_irq, maskable_irq}, "irq");
                chk(exp_req(local_int_ctrl_enable, local_int_pins),
                    local_int_req, "lintReq");
                chk(!ignore_numeric_error_n, ignore_numeric_error, "ign");
            end
        end
        chk(1, fetched, "refetch");
        $display("random test done");
        @(posedge ref_clk) lock_request <= 1;
        @(posedge ref_clk) lock_request <= 0;
        rst <= 1;
        repeat (2) @(negedge ref_clk);
        chk(1, bus_lock_n, "resetLock");
        chk(1, snoop_hit_n & snoop_hitm_n & !snoop_valid, "resetSnoop");
        $display("reset test done");
        summarize;
    end
endmodule // csil_sideband_tb
bind csil_sideband csil_sideband_asserts chk (.*);
